// ===== rtl/sdu_mem_if.sv
// Purpose: carrier between the engine and the setpoint table memory
// Assumes: one write port and one registered read port
// Notes: read data is valid the cycle after re
`timescale 1ns/1ps
interface sdu_mem_if;
  logic we;
  logic [3:0] be;
  logic [5:0] waddr;
  logic [31:0] wdata;
  logic re;
  logic [5:0] raddr;
  logic [31:0] rdata;
  modport user (output we, be, waddr, wdata, re, raddr, input rdata);
  modport mem (input we, be, waddr, wdata, re, raddr, output rdata);
endinterface

// ===== rtl/sdu_pkg.sv
// Purpose: constants and types shared by the setpoint detection unit
// Assumes: byte addresses on a 10-bit classic Wishbone address
// Notes: table field codes are what software writes into control words
package sdu_pkg;
  localparam int unsigned SDU_NUM_SP = 16;
  localparam int unsigned SDU_CH_W = 4;
  localparam int unsigned SDU_TBL_AW = 6;

  localparam logic [9:0] SDU_OFF_CTRL = 10'h000;
  localparam logic [9:0] SDU_OFF_FLAGS = 10'h004;
  localparam logic [9:0] SDU_OFF_IRQ_STAT = 10'h008;
  localparam logic [9:0] SDU_OFF_IRQ_MASK = 10'h00C;
  localparam logic [9:0] SDU_OFF_DOUT = 10'h010;
  localparam logic [1:0] SDU_TBL_SEL = 2'h1;

  localparam logic [1:0] SDU_WORD_LIMITS = 2'h0;
  localparam logic [1:0] SDU_WORD_VALUES = 2'h1;
  localparam logic [1:0] SDU_WORD_CTL = 2'h2;

  localparam int unsigned SDU_CTL_EN = 0;
  localparam int unsigned SDU_CTL_CRIT = 1;
  localparam int unsigned SDU_CTL_UPD = 4;
  localparam int unsigned SDU_CTL_ACT = 6;
  localparam int unsigned SDU_CTL_SEL = 8;
  localparam int unsigned SDU_CTL_MSK1 = 16;
  localparam int unsigned SDU_CTL_MSK2 = 24;
  localparam int unsigned SDU_DOUT_OE = 8;

  localparam logic [2:0] SDU_CRIT_EQ = 3'h0;
  localparam logic [2:0] SDU_CRIT_BELOW = 3'h1;
  localparam logic [2:0] SDU_CRIT_ABOVE = 3'h2;
  localparam logic [2:0] SDU_CRIT_INSIDE = 3'h3;
  localparam logic [2:0] SDU_CRIT_OUTSIDE = 3'h4;
  localparam logic [2:0] SDU_CRIT_HYST = 3'h5;

  localparam logic [1:0] SDU_UPD_NONE = 2'h0;
  localparam logic [1:0] SDU_UPD_TRUE = 2'h1;
  localparam logic [1:0] SDU_UPD_BOTH = 2'h2;

  localparam logic [1:0] SDU_ACT_NONE = 2'h0;
  localparam logic [1:0] SDU_ACT_DOUT = 2'h1;
  localparam logic [1:0] SDU_ACT_DAC = 2'h2;
  localparam logic [1:0] SDU_ACT_TIMER = 2'h3;

  localparam logic [3:0] SDU_IRQ_RST = 4'h0;
  localparam logic [7:0] SDU_DOUT_RST = 8'h00;

  typedef enum logic [1:0] {SDU_IDLE, SDU_RD_LIM, SDU_RD_VAL, SDU_EVAL} sdu_state_t;
endpackage

// ===== rtl/sdu_table_mem.sv
// Purpose: setpoint table, four words per channel slot
// Assumes: byte enables per lane, read data from a register
// Notes: contents are undefined until software loads them
`timescale 1ns/1ps
module sdu_table_mem
(
  input wire logic clk,
  sdu_mem_if.mem m
);
  genvar b;
  generate
    for (b = 0; b < 4; b++)
    begin : g_lane
      logic [7:0] lane [64];
      logic [7:0] rd_q;
      always_ff @(posedge clk)
      begin
        if (m.we && m.be[b])
          lane[m.waddr] <= m.wdata[8*b +: 8];
        if (m.re)
          rd_q <= lane[m.raddr];
      end
      assign m.rdata[8*b +: 8] = rd_q;
    end
  endgenerate
endmodule // sdu_table_mem

// ===== rtl/sdu_top.sv
// Purpose: setpoint detection on the scan data stream
// Assumes: one sample per handshake; smp_sos marks the first word of a scan
// Notes: table slot index equals the channel number in the scan group
// What this block does
// RL1: One setpoint per channel slot, sixteen slots, so never more than sixteen.
// RL2: Each setpoint holds a 16-bit upper and a 16-bit lower limit.
// RL3: Single-point criteria: equal to upper, below upper, or above lower.
// RL4: Window criteria: strictly inside both limits, or outside either limit.
// RL5: Hysteresis: above upper forces value one, below lower forces value two.
// RL6: Hysteresis samples inside the window change neither flag nor output.
// RL7: True-only mode applies value one when met, nothing otherwise.
// RL8: True-and-false mode applies value one when met, value two when not.
// RL9: Per-channel match flag is true when the criterion is met, else false.
// RL10: Match flags change only at scan boundaries, once per scan. Here a host run start also clears them.
// RL11: Match flags are offered as a word for the acquisition data stream.
// RL12: Comparison works on 16-bit words; counter halves are separate channels.
// RL13: Action targets the digital port, an analog output or a timer.
// RL14: The sample is compared as a plain unsigned 16-bit value.
// RL15: Host loads the whole table before starting the acquisition.
// RL16: Digital action carries an 8-bit data byte and an 8-bit mask.
// RL17: Analog action writes a 16-bit value to one of four outputs.
// RL18: Masked port update changes only bits whose mask bit is set.
//
// Chosen here: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
module sdu_top
  import sdu_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq,
  input wire logic smp_valid,
  output logic smp_ready,
  input wire logic smp_sos,
  input wire logic [sdu_pkg::SDU_CH_W-1:0] smp_chan,
  input wire logic [15:0] smp_data,
  output logic [sdu_pkg::SDU_NUM_SP-1:0] channel_match_flag,
  output logic [7:0] aux_digital_output_port,
  output logic aux_dout_oe,
  output logic dac_wr,
  output logic [1:0] dac_sel,
  output logic [15:0] dac_value,
  output logic timer_wr,
  output logic [1:0] timer_sel,
  output logic [15:0] timer_value
);
  import sdu_pkg::*;

  sdu_mem_if mif ();

  sdu_table_mem u_mem
  (
    .clk(clk),
    .m(mif.mem)
  );

  sdu_state_t st_q;
  logic run_q;
  logic [SDU_CH_W-1:0] ch_q;
  logic [15:0] x_q;
  logic [31:0] lim_q;
  logic [31:0] val_q;
  logic [SDU_NUM_SP-1:0] pend_q;
  logic [SDU_NUM_SP-1:0] flag_q;
  logic [3:0] irq_stat_q;
  logic [3:0] irq_mask_q;
  logic [7:0] port_q;
  logic oe_q;
  logic dac_wr_q;
  logic [1:0] dac_sel_q;
  logic [15:0] dac_val_q;
  logic tmr_wr_q;
  logic [1:0] tmr_sel_q;
  logic [15:0] tmr_val_q;
  logic ack_q;
  logic rd_wait_q;
  logic [31:0] dat_q;

  logic accept;
  logic take;
  logic bus_req;
  logic tbl_hit;
  logic bus_wr;
  logic port_free;
  logic tbl_rd_go;
  logic [31:0] reg_rdata;
  logic [31:0] ctl;
  logic [15:0] hi_lim;
  logic [15:0] lo_lim;
  logic sp_en;
  logic [2:0] crit;
  logic [1:0] upd;
  logic [1:0] act;
  logic met;
  logic decided;
  logic apply;
  logic [15:0] out_val;
  logic [7:0] out_msk;
  logic eval;
  logic commit;
  logic run_start;
  logic [3:0] ev;
  logic [3:0] irq_clr;
  logic [31:0] mask_merged;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
    begin
      if (sel[i])
        r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction

  // Sample stream: one word per four cycles while running, ready only when idle
  assign smp_ready = (st_q == SDU_IDLE);
  assign accept = smp_valid & smp_ready;
  assign take = accept & run_q;
  assign eval = (st_q == SDU_EVAL);

  // Bus decode
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q & ~rd_wait_q;
  assign tbl_hit = (wb_adr_i[9:8] == SDU_TBL_SEL);
  assign bus_wr = bus_req & wb_we_i;
  // Engine owns the read port while busy; table reads wait for a gap
  assign port_free = (st_q == SDU_IDLE) & ~(smp_valid & run_q);
  assign tbl_rd_go = bus_req & tbl_hit & ~wb_we_i & port_free;
  assign run_start = bus_wr & (wb_adr_i == SDU_OFF_CTRL) & wb_sel_i[0] & wb_dat_i[0] & ~run_q;
  assign commit = take & smp_sos;

  // Table port: bus writes, engine or bus reads
  always_comb
  begin
    mif.we = bus_wr & tbl_hit; // RL15
    mif.be = wb_sel_i;
    mif.waddr = wb_adr_i[7:2];
    mif.wdata = wb_dat_i;
    mif.re = 1'b0;
    mif.raddr = wb_adr_i[7:2];
    if (take)
    begin
      mif.re = 1'b1;
      mif.raddr = {smp_chan, SDU_WORD_LIMITS}; // RL1
    end
    else if (st_q == SDU_RD_LIM)
    begin
      mif.re = 1'b1;
      mif.raddr = {ch_q, SDU_WORD_VALUES};
    end
    else if (st_q == SDU_RD_VAL)
    begin
      mif.re = 1'b1;
      mif.raddr = {ch_q, SDU_WORD_CTL};
    end
    else if (tbl_rd_go)
    begin
      mif.re = 1'b1;
    end
  end

  // Engine sequence
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      st_q <= SDU_IDLE;
    else
    begin
      case (st_q)
        SDU_IDLE:
          if (take)
            st_q <= SDU_RD_LIM;
        SDU_RD_LIM:
          st_q <= SDU_RD_VAL;
        SDU_RD_VAL:
          st_q <= SDU_EVAL;
        SDU_EVAL:
          st_q <= SDU_IDLE;
        default:
          st_q <= SDU_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ch_q <= '0;
      x_q <= 16'h0000;
      lim_q <= 32'h00000000;
      val_q <= 32'h00000000;
    end
    else
    begin
      if (take)
      begin
        ch_q <= smp_chan;
        x_q <= smp_data; // RL12 RL14
      end
      if (st_q == SDU_RD_LIM)
        lim_q <= mif.rdata; // RL2
      if (st_q == SDU_RD_VAL)
        val_q <= mif.rdata;
    end
  end

  // Criterion evaluation on the control word just read
  assign ctl = mif.rdata;
  assign hi_lim = lim_q[31:16];
  assign lo_lim = lim_q[15:0];
  assign sp_en = ctl[SDU_CTL_EN];
  assign crit = ctl[SDU_CTL_CRIT +: 3];
  assign upd = ctl[SDU_CTL_UPD +: 2];
  assign act = ctl[SDU_CTL_ACT +: 2];

  always_comb
  begin
    met = 1'b0;
    decided = 1'b1;
    case (crit)
      SDU_CRIT_EQ:
        met = (x_q == hi_lim); // RL3
      SDU_CRIT_BELOW:
        met = (x_q < hi_lim); // RL3
      SDU_CRIT_ABOVE:
        met = (x_q > lo_lim); // RL3
      SDU_CRIT_INSIDE:
        met = (x_q > lo_lim) && (x_q < hi_lim); // RL4
      SDU_CRIT_OUTSIDE:
        met = (x_q < lo_lim) || (x_q > hi_lim); // RL4
      SDU_CRIT_HYST:
      begin
        met = (x_q > hi_lim); // RL5
        decided = (x_q > hi_lim) || (x_q < lo_lim); // RL6
      end
      default:
        decided = 1'b0;
    endcase
  end

  // Hysteresis forces both values regardless of update mode
  always_comb
  begin
    if (!sp_en || !decided)
      apply = 1'b0;
    else if (crit == SDU_CRIT_HYST)
      apply = 1'b1; // RL5
    else if (met)
      apply = (upd == SDU_UPD_TRUE) || (upd == SDU_UPD_BOTH); // RL7 RL8
    else
      apply = (upd == SDU_UPD_BOTH); // RL8
  end

  assign out_val = met ? val_q[31:16] : val_q[15:0];
  assign out_msk = met ? ctl[SDU_CTL_MSK1 +: 8] : ctl[SDU_CTL_MSK2 +: 8]; // RL16

  // Pending flags; published only at the next start of scan
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      pend_q <= '0;
    else if (run_start)
      pend_q <= '0;
    else if (eval)
    begin
      if (!sp_en)
        pend_q[ch_q] <= 1'b0;
      else if (decided)
        pend_q[ch_q] <= met; // RL9 RL6
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      flag_q <= '0;
    else if (run_start)
      flag_q <= '0;
    else if (commit)
      flag_q <= pend_q; // RL10
  end

  assign channel_match_flag = flag_q; // RL11

  // Run control
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      run_q <= 1'b0;
    else if (bus_wr && wb_adr_i == SDU_OFF_CTRL && wb_sel_i[0])
      run_q <= wb_dat_i[0];
  end

  // Digital port: direct host write enables the driver, setpoints merge masked and win over a same-cycle host write
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      port_q <= SDU_DOUT_RST;
      oe_q <= 1'b0;
    end
    else if (eval && apply && act == SDU_ACT_DOUT)
      port_q <= (port_q & ~out_msk) | (out_val[7:0] & out_msk); // RL13 RL18
    else if (bus_wr && wb_adr_i == SDU_OFF_DOUT && wb_sel_i[0])
    begin
      port_q <= wb_dat_i[7:0];
      oe_q <= 1'b1;
    end
  end

  // Analog and timer updates, one-cycle write strobes
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      dac_wr_q <= 1'b0;
      dac_sel_q <= 2'h0;
      dac_val_q <= 16'h0000;
    end
    else
    begin
      dac_wr_q <= eval & apply & (act == SDU_ACT_DAC); // RL13
      if (eval && apply && act == SDU_ACT_DAC)
      begin
        dac_sel_q <= ctl[SDU_CTL_SEL +: 2]; // RL17
        dac_val_q <= out_val; // RL17
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      tmr_wr_q <= 1'b0;
      tmr_sel_q <= 2'h0;
      tmr_val_q <= 16'h0000;
    end
    else
    begin
      tmr_wr_q <= eval & apply & (act == SDU_ACT_TIMER); // RL13
      if (eval && apply && act == SDU_ACT_TIMER)
      begin
        tmr_sel_q <= ctl[SDU_CTL_SEL +: 2];
        tmr_val_q <= out_val;
      end
    end
  end

  assign aux_digital_output_port = port_q;
  assign aux_dout_oe = oe_q;
  assign dac_wr = dac_wr_q;
  assign dac_sel = dac_sel_q;
  assign dac_value = dac_val_q;
  assign timer_wr = tmr_wr_q;
  assign timer_sel = tmr_sel_q;
  assign timer_value = tmr_val_q;

  // Interrupt status: set wins over a same-cycle clear
  assign ev[0] = commit & (pend_q != flag_q);
  assign ev[1] = eval & apply & (act == SDU_ACT_DOUT);
  assign ev[2] = eval & apply & (act == SDU_ACT_DAC);
  assign ev[3] = eval & apply & (act == SDU_ACT_TIMER);
  assign irq_clr = (bus_wr && wb_adr_i == SDU_OFF_IRQ_STAT && wb_sel_i[0]) ? wb_dat_i[3:0] : 4'h0;

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      irq_stat_q <= SDU_IRQ_RST;
    else
      irq_stat_q <= (irq_stat_q & ~irq_clr) | ev;
  end

  // Only four mask bits exist; upper lanes are dropped on purpose
  assign mask_merged = merge({28'h0000000, irq_mask_q}, wb_dat_i, wb_sel_i);

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      irq_mask_q <= SDU_IRQ_RST;
    else if (bus_wr && wb_adr_i == SDU_OFF_IRQ_MASK)
      irq_mask_q <= mask_merged[3:0];
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // Register read mux; unmapped offsets read zero
  always_comb
  begin
    reg_rdata = 32'h00000000;
    case (wb_adr_i)
      SDU_OFF_CTRL:
        reg_rdata = {31'h00000000, run_q};
      SDU_OFF_FLAGS:
        reg_rdata = {pend_q, flag_q};
      SDU_OFF_IRQ_STAT:
        reg_rdata = {28'h0000000, irq_stat_q};
      SDU_OFF_IRQ_MASK:
        reg_rdata = {28'h0000000, irq_mask_q};
      SDU_OFF_DOUT:
        reg_rdata = {23'h000000, oe_q, port_q};
      default:
        reg_rdata = 32'h00000000;
    endcase
  end

  // Ack one cycle after a request, two after a table read gets the port
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      ack_q <= 1'b0;
      rd_wait_q <= 1'b0;
      dat_q <= 32'h00000000;
    end
    else
    begin
      rd_wait_q <= tbl_rd_go;
      ack_q <= (bus_req & ~(tbl_hit & ~wb_we_i)) | rd_wait_q;
      if (rd_wait_q)
        dat_q <= mif.rdata;
      else if (bus_req && !tbl_hit)
        dat_q <= reg_rdata;
      else
        dat_q <= 32'h00000000;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
endmodule // sdu_top

// ===== sim/sdu_properties.sv
// Purpose: port-level checks of the setpoint detection unit
// Assumes: bound to sdu_top, one clock, synchronous reset_n
// Notes: latencies follow the engine's four-cycle sample walk
`timescale 1ns/1ps
module sdu_properties
  import sdu_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic wb_ack_o,
  input wire logic smp_valid,
  input wire logic smp_ready,
  input wire logic smp_sos,
  input wire logic [sdu_pkg::SDU_NUM_SP-1:0] channel_match_flag,
  input wire logic [7:0] aux_digital_output_port,
  input wire logic aux_dout_oe,
  input wire logic dac_wr,
  input wire logic timer_wr
);
  logic acc;
  logic wreq;
  assign acc = smp_valid && smp_ready;
  assign wreq = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_wr_ack;
    wreq |=> wb_ack_o;
  endproperty
  a_wr_ack: assert property (p_wr_ack) else $error("write not acked next cycle");
  property p_busy;
    acc |=> !smp_ready [*3] ##1 smp_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("sample engine busy time wrong");
  property p_flag;
    !$stable(channel_match_flag) |-> $past(acc && smp_sos) || $past(wreq && wb_adr_i == SDU_OFF_CTRL);
  endproperty
  a_flag: assert property (p_flag) else $error("match flag moved off scan start");
  property p_dac;
    dac_wr |-> $past(acc, 4) && !timer_wr;
  endproperty
  a_dac: assert property (p_dac) else $error("analog write at wrong time");
  property p_tmr;
    timer_wr |=> !timer_wr;
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer write not a pulse");
  property p_port;
    !$stable(aux_digital_output_port) |-> $past(acc, 4) || $past(wreq && wb_adr_i == SDU_OFF_DOUT);
  endproperty
  a_port: assert property (p_port) else $error("port changed without cause");
  property p_oe;
    $rose(aux_dout_oe) |-> $past(wreq && wb_adr_i == SDU_OFF_DOUT);
  endproperty
  a_oe: assert property (p_oe) else $error("port enabled without host write");
endmodule // sdu_properties

bind sdu_top sdu_properties u_props (.clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o,
  .smp_valid, .smp_ready, .smp_sos, .channel_match_flag, .aux_digital_output_port, .aux_dout_oe, .dac_wr,
  .timer_wr);

// ===== sim/sdu_scan_src.sv
// Purpose: scan sequencer model feeding channel words
// Assumes: one word per handshake, held until ready seen
// Notes: released data shows its inverse, never a stale copy
`timescale 1ns/1ps
module sdu_scan_src
  import sdu_pkg::*;
(
  input wire logic clk,
  input wire logic smp_ready,
  output logic smp_valid,
  output logic smp_sos,
  output logic [sdu_pkg::SDU_CH_W-1:0] smp_chan,
  output logic [15:0] smp_data
);
  initial
  begin
    smp_valid = 1'b0;
    smp_sos = 1'b0;
    smp_chan = 4'h0;
    smp_data = 16'h0000;
  end
  task automatic send(input logic s, input logic [3:0] c, input logic [15:0] d);
    @(posedge clk);
    smp_valid <= 1'b1;
    smp_sos <= s;
    smp_chan <= c;
    smp_data <= d;
    do @(posedge clk); while (smp_ready !== 1'b1);
    smp_valid <= 1'b0;
    smp_sos <= ~s;
    smp_chan <= ~c;
    smp_data <= ~d;
  endtask
endmodule // sdu_scan_src

// ===== sim/sdu_top_tb.sv
// Purpose: self-checking bench for the setpoint detection unit
// Assumes: classic Wishbone host, scan model as sample source
// Notes: every slot's control word cleared before run since the table has no reset
`timescale 1ns/1ps
module sdu_top_tb;
  import sdu_pkg::*;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, irq, smp_valid, smp_ready, smp_sos, aux_dout_oe, dac_wr, timer_wr;
  logic [3:0] smp_chan;
  logic [15:0] smp_data, channel_match_flag, dac_value, timer_value;
  logic [7:0] aux_digital_output_port;
  logic [1:0] dac_sel, timer_sel;
  logic [31:0] r;
  int mismatches = 0;
  int cmp_count = 0;
  always #4 clk = ~clk;
  sdu_top DUT (.clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .irq, .smp_valid, .smp_ready, .smp_sos, .smp_chan, .smp_data, .channel_match_flag,
    .aux_digital_output_port, .aux_dout_oe, .dac_wr, .dac_sel, .dac_value, .timer_wr, .timer_sel, .timer_value);
  sdu_scan_src u_src (.clk, .smp_ready, .smp_valid, .smp_sos, .smp_chan, .smp_data);
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_sel_i <= 4'h0;
  endtask
  function automatic logic [31:0] mk(input logic [2:0] c, input logic [1:0] u, input logic [1:0] a,
    input logic [1:0] s, input logic [7:0] m1, input logic [7:0] m2);
    return {m2, m1, 6'h0, s, a, u, c, 1'b1};
  endfunction
  task automatic sp(input logic [3:0] c, input logic [31:0] lim, input logic [31:0] val, input logic [31:0] ctl);
    wb(1'b1, {SDU_TBL_SEL, c, SDU_WORD_LIMITS, 2'h0}, lim);
    wb(1'b1, {SDU_TBL_SEL, c, SDU_WORD_VALUES, 2'h0}, val);
    wb(1'b1, {SDU_TBL_SEL, c, SDU_WORD_CTL, 2'h0}, ctl);
  endtask
  // Returns once the evaluation's effects are visible
  task automatic hit(input logic s, input logic [3:0] c, input logic [15:0] d);
    u_src.send(s, c, d);
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic t_regs;
    logic [9:0] a[6] = '{SDU_OFF_CTRL, SDU_OFF_FLAGS, SDU_OFF_IRQ_STAT, SDU_OFF_IRQ_MASK, SDU_OFF_DOUT, 10'h020};
    foreach (a[i])
    begin
      wb(1'b0, a[i], 32'h0);
      cmp(r, 32'h0);
    end
    wb(1'b1, SDU_OFF_FLAGS, 32'hFFFFFFFF);
    wb(1'b0, SDU_OFF_FLAGS, 32'h0);
    cmp(r, 32'h0);
    cmp({31'h0, aux_dout_oe}, 32'h0);
    for (int i = 0; i < 16; i++)
      wb(1'b1, {SDU_TBL_SEL, i[3:0], SDU_WORD_CTL, 2'h0}, 32'h0);
    wb(1'b1, SDU_OFF_DOUT, 32'h33);
    wb(1'b0, SDU_OFF_DOUT, 32'h0);
    cmp(r, 32'h133);
    wb(1'b1, SDU_OFF_CTRL, 32'h1);
  endtask
  task automatic t_crit;
    logic [15:0] d[2][5] = '{'{16'h0064, 16'h0064, 16'h0032, 16'h0033, 16'h0065},
      '{16'h0063, 16'h0063, 16'h8000, 16'h0064, 16'h0032}};
    logic [15:0] e[2] = '{16'h0019, 16'h0006};
    for (int i = 0; i < 5; i++)
      sp(i[3:0], {16'd100, 16'd50}, 32'h0, mk(i[2:0], SDU_UPD_NONE, SDU_ACT_NONE, 2'h0, 8'h0, 8'h0));
    for (int k = 0; k < 2; k++)
    begin
      for (int i = 0; i < 5; i++)
        hit(i == 0, i[3:0], d[k][i]);
      hit(1'b1, 4'hE, 16'h0);
      cmp({16'h0, channel_match_flag}, {16'h0, e[k]});
      wb(1'b0, SDU_OFF_FLAGS, 32'h0);
      cmp({16'h0, r[15:0]}, {16'h0, e[k]});
    end
  endtask
  task automatic t_hyst;
    sp(4'h5, {16'd1000, 16'd500}, 32'h00A5005A, mk(SDU_CRIT_HYST, SDU_UPD_NONE, SDU_ACT_DOUT, 2'h0, 8'hF0, 8'h0F));
    wb(1'b1, SDU_OFF_IRQ_STAT, 32'hF);
    hit(1'b1, 4'h5, 16'd1200);
    cmp({24'h0, aux_digital_output_port}, 32'hA3);
    cmp({31'h0, irq}, 32'h0);
    wb(1'b1, SDU_OFF_IRQ_MASK, 32'h2);
    cmp({31'h0, irq}, 32'h1);
    wb(1'b1, SDU_OFF_IRQ_STAT, 32'h2);
    cmp({31'h0, irq}, 32'h0);
    hit(1'b1, 4'h5, 16'd700);
    cmp({31'h0, channel_match_flag[5]}, 32'h1);
    cmp({23'h0, irq, aux_digital_output_port}, 32'hA3);
    hit(1'b1, 4'h5, 16'd400);
    cmp({31'h0, channel_match_flag[5]}, 32'h1);
    cmp({23'h0, irq, aux_digital_output_port}, 32'h1AA);
    hit(1'b1, 4'hE, 16'h0);
    cmp({31'h0, channel_match_flag[5]}, 32'h0);
    wb(1'b1, SDU_OFF_IRQ_MASK, 32'h0);
  endtask
  task automatic t_upd;
    logic [3:0] c[5] = '{4'hF, 4'hF, 4'h6, 4'h6, 4'h7};
    logic [15:0] d[5] = '{16'd5, 16'd20, 16'd10, 16'd11, 16'd7};
    logic [31:0] e[5] = '{32'hB1234, 32'h0, 32'h6CAFE, 32'h6BEEF, 32'h0};
    logic [31:0] g;
    sp(4'hF, {16'd10, 16'd0}, 32'h12344321, mk(SDU_CRIT_BELOW, SDU_UPD_TRUE, SDU_ACT_DAC, 2'h3, 8'h0, 8'h0));
    sp(4'h6, {16'd0, 16'd10}, 32'hBEEFCAFE, mk(SDU_CRIT_ABOVE, SDU_UPD_BOTH, SDU_ACT_TIMER, 2'h2, 8'h0, 8'h0));
    sp(4'h7, {16'd7, 16'd0}, 32'h11112222, mk(SDU_CRIT_EQ, SDU_UPD_NONE, SDU_ACT_DAC, 2'h1, 8'h0, 8'h0));
    // Table read back goes through the waited port path
    wb(1'b0, {SDU_TBL_SEL, 4'h6, SDU_WORD_LIMITS, 2'h0}, 32'h0);
    cmp(r, 32'h0000000A);
    foreach (c[i])
    begin
      hit(1'b0, c[i], d[i]);
      g = {12'h0, dac_wr, timer_wr, dac_wr ? dac_sel : (timer_wr ? timer_sel : 2'h0),
        dac_wr ? dac_value : (timer_wr ? timer_value : 16'h0)};
      cmp(g, e[i]);
    end
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_crit();
    t_hyst();
    t_upd();
    summarize();
  end
  // Whole run needs a few hundred cycles
  initial
  begin
    #160000;
    mismatches++;
    summarize();
  end
endmodule // sdu_top_tb
